// >>> inc/pgc_cfg.svh
// register indices, field positions, reset values of the packet generator/checker block
// assumes byte address = 4 * index on a 32-bit bus
`ifndef PGC_CFG_SVH
`define PGC_CFG_SVH

// ****************************************
// register indices
// ****************************************
`define PGC_IDX_PAY_LO   12'h625
`define PGC_IDX_PAY_MID  12'h626
`define PGC_IDX_PAY_HI   12'h627
`define PGC_IDX_DA_LO    12'h628
`define PGC_IDX_DA_MID   12'h629
`define PGC_IDX_DA_HI    12'h62A
`define PGC_IDX_FLAGS    12'h638
`define PGC_IDX_CNT_LO   12'h639
`define PGC_IDX_CNT_HI   12'h63A
`define PGC_IDX_ERR_CNT  12'h63B
`define PGC_IDX_CTRL     12'h640

// ****************************************
// fields and reset values
// ****************************************
`define PGC_FLAG_TX_BIT  0
`define PGC_FLAG_RX_BIT  1
`define PGC_CTRL_VLD_LSB 0
`define PGC_CTRL_VLD_MSB 2
`define PGC_CTRL_EN_BIT  3
`define PGC_RST_WORD     16'h0000
`define PGC_RST_VLD      3'h2
`define PGC_RST_EN       1'b1
`define PGC_MAX_VLD      3'h6
`define PGC_DA_BYTES     3'h6
`define PGC_FILL_BYTE    8'h00

`endif

// >>> inc/pgc_pkg.sv
// types shared by the packet generator/checker block
// assumes nothing of its surroundings
package pgc_pkg;
  typedef logic [15:0] pgc_word_t;
  typedef logic [7:0]  pgc_byte_t;
  typedef logic [2:0]  pgc_idx_t;
  typedef logic [47:0] pgc_pat_t;
  typedef enum logic [1:0] {
    PGC_SEQ_IDLE,
    PGC_SEQ_LOW,
    PGC_SEQ_HIGH
  } pgc_seq_e;
endpackage

// >>> inc/pgc_pat_if.sv
// link between register file and pattern byte source
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface pgc_pat_if;
  import pgc_pkg::*;
  pgc_pat_t  pattern;
  pgc_idx_t  vld_bytes;
  logic      req;
  pgc_idx_t  idx;
  pgc_byte_t pat_byte;
  logic      byte_vld;
  logic      is_pat;
  modport ctrl (output pattern, output vld_bytes, output req, output idx,
                input pat_byte, input byte_vld, input is_pat);
  modport src  (input pattern, input vld_bytes, input req, input idx,
                output pat_byte, output byte_vld, output is_pat);
endinterface

// >>> design/pgc_pat_src.sv
// pattern byte source: returns one pattern or fill byte per request, one cycle later
// assumes clk_i/rst_i shared with the register file
`timescale 1ns/1ps
`include "pgc_cfg.svh"
module pgc_pat_src (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request and answer
  pgc_pat_if.src    pif
);
  import pgc_pkg::*;

  // ****************************************
  // valid byte limit
  // ****************************************
  pgc_idx_t eff_vld;
  always_comb begin
    eff_vld = (pif.vld_bytes > `PGC_MAX_VLD) ? `PGC_MAX_VLD : pif.vld_bytes; // [R8]
  end

  // ****************************************
  // byte select
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pif.pat_byte <= `PGC_FILL_BYTE;
      pif.byte_vld <= 1'b0;
      pif.is_pat   <= 1'b0;
    end else begin
      pif.byte_vld <= pif.req;
      if (pif.req) begin
        pif.is_pat <= (pif.idx < eff_vld); // [R8]
        if (pif.idx < eff_vld) begin
          pif.pat_byte <= pif.pattern[{pif.idx, 3'b000} +: 8]; // [R1]
        end else begin
          pif.pat_byte <= `PGC_FILL_BYTE;
        end
      end
    end
  end

  a_vld_limit: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    pif.req && (pif.idx >= eff_vld) |=> !pif.is_pat && pif.pat_byte == `PGC_FILL_BYTE)
    else $error("pattern byte beyond valid count");
  a_pat_byte: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    pif.req && (pif.idx < eff_vld)
      |=> pif.is_pat && pif.pat_byte == $past(pif.pattern[{pif.idx, 3'b000} +: 8]))
    else $error("pattern byte mismatch");
endmodule

// >>> design/pgc_top.sv
// packet generator/checker configuration, status and transmit statistics
// assumes a classic Wishbone master and end-of-packet strobes from the datapath
`timescale 1ns/1ps
`include "pgc_cfg.svh"

// Function
// R1: three read/write words hold 48-bit payload pattern, reset zero.
// R2: three read/write words hold 48-bit match value compared to destination address.
// R3: flag bit 1 shows whether last received copper line packet had CRC error.
// R4: flag bit 0 shows whether last transmitted packet had CRC error.
// R5: flag register bits 15 to 2 read as zero.
// R6: low 16 bits of sent packet counter readable, reset zero.
// R7: reading low, high, error count words consecutively clears all statistics.
// R8: generator inserts zero to six pattern bytes; seven acts as six.
// R9: upper 16 counter bits readable, cleared by the same read sequence.
// R10: errored transmit packets counted in 16 bits, cleared by the sequence.
// R11: sent counter increments per completed transmit packet while statistics enabled.
module pgc_top #(
  parameter int CNT_W = 32,
  parameter int ERR_W = 16
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [13:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // transmit path packet ends
  input  wire logic              tx_pkt_end_i,
  input  wire logic              tx_crc_bad_i,
  // receive path from copper line
  input  wire logic              rx_byte_vld_i,
  input  wire logic              rx_sof_i,
  input  wire pgc_pkg::pgc_byte_t rx_byte_i,
  input  wire logic              rx_pkt_end_i,
  input  wire logic              rx_crc_bad_i,
  // generator byte port
  input  wire logic              gen_req_i,
  input  wire pgc_pkg::pgc_idx_t gen_idx_i,
  output pgc_pkg::pgc_byte_t     gen_byte_o,
  output logic                   gen_byte_vld_o,
  output logic                   gen_is_pat_o,
  // destination address check
  output logic                   da_match_vld_o,
  output logic                   da_match_o
);
  import pgc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  pgc_word_t        pay_r [3];
  pgc_word_t        da_r  [3];
  pgc_idx_t         vld_r;
  logic             en_r;
  logic             tx_bad_r;
  logic             rx_bad_r;
  logic [CNT_W-1:0] cnt_r;
  logic [ERR_W-1:0] err_r;
  pgc_seq_e         seq_r;
  logic             clr;
  logic [39:0]      da_sh_r;
  pgc_idx_t         da_cnt_r;
  pgc_pat_t         da_val;
  pgc_pat_t         pay_val;

  // ****************************************
  // bus decode
  // ****************************************
  logic      acc;
  logic      wr;
  logic      rd;
  logic [11:0] idx;
  pgc_word_t wdat;
  pgc_word_t wmask;

  always_comb begin
    acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr    = acc && wb_we_i;
    rd    = acc && !wb_we_i;
    idx   = wb_adr_i[13:2];
    wdat  = wb_dat_i[15:0];
    wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= acc;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 3; i++) begin
        pay_r[i] <= `PGC_RST_WORD; // [R1]
        da_r[i]  <= `PGC_RST_WORD; // [R2]
      end
      vld_r <= `PGC_RST_VLD;
      en_r  <= `PGC_RST_EN;
    end else if (wr) begin
      if (idx == `PGC_IDX_PAY_LO) begin
        pay_r[0] <= (pay_r[0] & ~wmask) | (wdat & wmask); // [R1]
      end else if (idx == `PGC_IDX_PAY_MID) begin
        pay_r[1] <= (pay_r[1] & ~wmask) | (wdat & wmask); // [R1]
      end else if (idx == `PGC_IDX_PAY_HI) begin
        pay_r[2] <= (pay_r[2] & ~wmask) | (wdat & wmask); // [R1]
      end else if (idx == `PGC_IDX_DA_LO) begin
        da_r[0] <= (da_r[0] & ~wmask) | (wdat & wmask); // [R2]
      end else if (idx == `PGC_IDX_DA_MID) begin
        da_r[1] <= (da_r[1] & ~wmask) | (wdat & wmask); // [R2]
      end else if (idx == `PGC_IDX_DA_HI) begin
        da_r[2] <= (da_r[2] & ~wmask) | (wdat & wmask); // [R2]
      end else if (idx == `PGC_IDX_CTRL && wb_sel_i[0]) begin
        vld_r <= wdat[`PGC_CTRL_VLD_MSB:`PGC_CTRL_VLD_LSB]; // [R8]
        en_r  <= wdat[`PGC_CTRL_EN_BIT]; // [R11]
      end
    end
  end

  always_comb begin
    da_val  = {da_r[2], da_r[1], da_r[0]};
    pay_val = {pay_r[2], pay_r[1], pay_r[0]};
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= 32'h0000_0000;
      if (idx == `PGC_IDX_PAY_LO) begin
        wb_dat_o[15:0] <= pay_r[0];
      end else if (idx == `PGC_IDX_PAY_MID) begin
        wb_dat_o[15:0] <= pay_r[1];
      end else if (idx == `PGC_IDX_PAY_HI) begin
        wb_dat_o[15:0] <= pay_r[2];
      end else if (idx == `PGC_IDX_DA_LO) begin
        wb_dat_o[15:0] <= da_r[0];
      end else if (idx == `PGC_IDX_DA_MID) begin
        wb_dat_o[15:0] <= da_r[1];
      end else if (idx == `PGC_IDX_DA_HI) begin
        wb_dat_o[15:0] <= da_r[2];
      end else if (idx == `PGC_IDX_FLAGS) begin
        wb_dat_o[`PGC_FLAG_RX_BIT] <= rx_bad_r; // [R3] [R5]
        wb_dat_o[`PGC_FLAG_TX_BIT] <= tx_bad_r; // [R4]
      end else if (idx == `PGC_IDX_CNT_LO) begin
        wb_dat_o[15:0] <= cnt_r[15:0]; // [R6]
      end else if (idx == `PGC_IDX_CNT_HI) begin
        wb_dat_o[15:0] <= cnt_r[31:16]; // [R9]
      end else if (idx == `PGC_IDX_ERR_CNT) begin
        wb_dat_o[15:0] <= err_r[15:0]; // [R10]
      end else if (idx == `PGC_IDX_CTRL) begin
        wb_dat_o[`PGC_CTRL_VLD_MSB:`PGC_CTRL_VLD_LSB] <= vld_r;
        wb_dat_o[`PGC_CTRL_EN_BIT] <= en_r;
      end
    end
  end

  // ****************************************
  // statistics read sequence
  // ****************************************
  always_comb begin
    clr = rd && idx == `PGC_IDX_ERR_CNT && seq_r == PGC_SEQ_HIGH; // [R7]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r <= PGC_SEQ_IDLE;
    end else if (acc) begin
      case (seq_r)
        PGC_SEQ_LOW: begin
          seq_r <= (rd && idx == `PGC_IDX_CNT_HI) ? PGC_SEQ_HIGH : PGC_SEQ_IDLE; // [R7]
        end
        default: begin
          seq_r <= (rd && idx == `PGC_IDX_CNT_LO) ? PGC_SEQ_LOW : PGC_SEQ_IDLE; // [R7]
        end
      endcase
      if (rd && idx == `PGC_IDX_CNT_LO) begin
        seq_r <= PGC_SEQ_LOW;
      end
    end
  end

  // ****************************************
  // counters, a packet in the clear cycle survives
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0; // [R6]
    end else if (clr) begin
      cnt_r <= (tx_pkt_end_i && en_r) ? CNT_W'(1) : '0; // [R7] [R9]
    end else if (tx_pkt_end_i && en_r) begin
      cnt_r <= cnt_r + CNT_W'(1); // [R11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r <= '0;
    end else if (clr) begin
      err_r <= (tx_pkt_end_i && tx_crc_bad_i && en_r) ? ERR_W'(1) : '0; // [R10]
    end else if (tx_pkt_end_i && tx_crc_bad_i && en_r) begin
      err_r <= err_r + ERR_W'(1); // [R10]
    end
  end

  // ****************************************
  // checksum flags
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bad_r <= 1'b0;
      rx_bad_r <= 1'b0;
    end else begin
      if (tx_pkt_end_i) begin
        tx_bad_r <= tx_crc_bad_i; // [R4]
      end
      if (rx_pkt_end_i) begin
        rx_bad_r <= rx_crc_bad_i; // [R3]
      end
    end
  end

  // ****************************************
  // destination address match
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      da_sh_r        <= 40'h00_0000_0000;
      da_cnt_r       <= `PGC_DA_BYTES;
      da_match_vld_o <= 1'b0;
      da_match_o     <= 1'b0;
    end else begin
      da_match_vld_o <= 1'b0;
      if (rx_byte_vld_i && rx_sof_i) begin
        da_sh_r  <= {32'h0000_0000, rx_byte_i};
        da_cnt_r <= 3'h1;
      end else if (rx_byte_vld_i && da_cnt_r < `PGC_DA_BYTES) begin
        da_sh_r  <= {da_sh_r[31:0], rx_byte_i};
        da_cnt_r <= da_cnt_r + 3'h1;
        if (da_cnt_r == `PGC_DA_BYTES - 3'h1) begin
          da_match_vld_o <= 1'b1;
          da_match_o     <= ({da_sh_r, rx_byte_i} == da_val); // [R2]
        end
      end
    end
  end

  // ****************************************
  // pattern byte source
  // ****************************************
  pgc_pat_if pif ();

  always_comb begin
    pif.pattern   = pay_val; // [R1]
    pif.vld_bytes = vld_r; // [R8]
    pif.req       = gen_req_i;
    pif.idx       = gen_idx_i;
  end

  pgc_pat_src u_pat_src (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pif   (pif.src)
  );

  assign gen_byte_o     = pif.pat_byte;
  assign gen_byte_vld_o = pif.byte_vld;
  assign gen_is_pat_o   = pif.is_pat;

  // ****************************************
  // checks
  // ****************************************
  a_pay_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    wr && idx == `PGC_IDX_PAY_MID && wb_sel_i[1:0] == 2'b11 |=> pay_r[1] == $past(wdat))
    else $error("payload word not written");
  a_da_write: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    wr && idx == `PGC_IDX_DA_HI && wb_sel_i[1:0] == 2'b11 |=> da_r[2] == $past(wdat))
    else $error("match word not written");
  a_rx_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    rx_pkt_end_i |=> rx_bad_r == $past(rx_crc_bad_i) ##1 ($past(rx_pkt_end_i) || $stable(rx_bad_r)))
    else $error("rx checksum flag wrong");
  a_tx_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    rd && idx == `PGC_IDX_FLAGS |=> wb_ack_o && wb_dat_o[`PGC_FLAG_TX_BIT] == $past(tx_bad_r))
    else $error("tx checksum flag wrong");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    rd && idx == `PGC_IDX_FLAGS |=> wb_dat_o[31:2] == 30'h0000_0000)
    else $error("reserved flag bits not zero");
  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    tx_pkt_end_i && en_r && !clr |=> cnt_r == $past(cnt_r) + CNT_W'(1))
    else $error("sent counter did not step");
  a_seq_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    rd && idx == `PGC_IDX_CNT_LO ##1 !acc [*2] ##1 rd && idx == `PGC_IDX_CNT_HI
      ##1 !acc [*2] ##1 rd && idx == `PGC_IDX_ERR_CNT && !tx_pkt_end_i
      |=> cnt_r == '0 && err_r == '0)
    else $error("read sequence did not clear");
  a_err_step: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    tx_pkt_end_i && !tx_crc_bad_i && !clr |=> err_r == $past(err_r))
    else $error("error counter moved on good packet");
  a_da_result: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    rx_byte_vld_i && !rx_sof_i && da_cnt_r == 3'h5
      |=> da_match_vld_o && da_match_o == ($past({da_sh_r, rx_byte_i}) == da_val))
    else $error("destination address compare wrong");
endmodule

// >>> dv/pgc_far_end.sv
// far side model: transmit packet ends and received copper line packets
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module pgc_far_end (
  // clock
  input  wire logic  clk_i,
  // transmit packet ends
  output logic       tx_pkt_end_o,
  output logic       tx_crc_bad_o,
  // received packets
  output logic       rx_byte_vld_o,
  output logic       rx_sof_o,
  output logic [7:0] rx_byte_o,
  output logic       rx_pkt_end_o,
  output logic       rx_crc_bad_o
);
  initial begin
    tx_pkt_end_o = 1'b0;
    tx_crc_bad_o = 1'b0;
    rx_byte_vld_o = 1'b0;
    rx_sof_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_pkt_end_o = 1'b0;
    rx_crc_bad_o = 1'b0;
  end
  // one packet end, status released to its inverse
  task automatic send_tx(input logic bad);
    @(posedge clk_i);
    tx_pkt_end_o <= 1'b1;
    tx_crc_bad_o <= bad;
    @(posedge clk_i);
    tx_pkt_end_o <= 1'b0;
    tx_crc_bad_o <= ~bad;
  endtask
  // six destination address bytes, gap idle cycles after each of them
  task automatic send_rx(input logic [47:0] da, input logic bad, input int gap);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      rx_byte_vld_o <= 1'b1;
      rx_sof_o <= (k == 0);
      rx_byte_o <= da[47-8*k -: 8];
      repeat (gap) begin
        @(posedge clk_i);
        rx_byte_vld_o <= 1'b0;
        rx_sof_o <= 1'b0;
        rx_byte_o <= ~rx_byte_o;
      end
    end
    @(posedge clk_i);
    rx_byte_vld_o <= 1'b0;
    rx_sof_o <= 1'b0;
    rx_byte_o <= ~da[7:0];
    rx_pkt_end_o <= 1'b1;
    rx_crc_bad_o <= bad;
    @(posedge clk_i);
    rx_pkt_end_o <= 1'b0;
    rx_crc_bad_o <= ~bad;
  endtask
endmodule

// >>> dv/pkt_gen_check_stats_tb.sv
// self-checking bench for the packet generator/checker registers
// assumes ack one cycle after a taken request, byte address = 4 * index
`timescale 1ns/1ps
`include "pgc_cfg.svh"
module pkt_gen_check_stats_tb;
  import pgc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        gen_req = 1'b0;
  pgc_idx_t    gen_idx = 3'h0;
  pgc_byte_t   gen_byte_o;
  logic        gen_byte_vld_o, gen_is_pat_o, da_match_vld_o, da_match_o;
  logic        tx_end, tx_bad, rx_vld, rx_sof, rx_end, rx_bad;
  logic [7:0]  rx_byte;
  int          fail_count = 0;
  int          num_checks = 0;
  logic [31:0] seed = 32'd25;
  logic [31:0] r = 32'h00000000;
  logic [15:0] mw [6];
  logic [15:0] q;
  int          cnt = 0;
  int          err = 0;
  logic        txf = 1'b0;
  logic        rxf = 1'b0;
  logic        b;
  logic        last_match = 1'b0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (da_match_vld_o === 1'b1) begin
      last_match <= da_match_o;
    end
  end

  pgc_top pgc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_pkt_end_i(tx_end), .tx_crc_bad_i(tx_bad),
    .rx_byte_vld_i(rx_vld), .rx_sof_i(rx_sof), .rx_byte_i(rx_byte), .rx_pkt_end_i(rx_end),
    .rx_crc_bad_i(rx_bad), .gen_req_i(gen_req), .gen_idx_i(gen_idx),
    .gen_byte_o(gen_byte_o), .gen_byte_vld_o(gen_byte_vld_o), .gen_is_pat_o(gen_is_pat_o),
    .da_match_vld_o(da_match_vld_o), .da_match_o(da_match_o));
  pgc_far_end pgc_far_end_i (.clk_i(clk_i), .tx_pkt_end_o(tx_end), .tx_crc_bad_o(tx_bad),
    .rx_byte_vld_o(rx_vld), .rx_sof_o(rx_sof), .rx_byte_o(rx_byte),
    .rx_pkt_end_o(rx_end), .rx_crc_bad_o(rx_bad));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {r[31:16], d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, wb_ack_o, 1'b1);
    end
  endtask
  task automatic rd(input logic [11:0] idx, input logic [15:0] e);
    wb(1'b0, idx, 16'h0000);
    cmp_reg(q, e);
  endtask
  task automatic gen_chk(input int k, input int v);
    logic [47:0] p;
    p = {mw[2], mw[1], mw[0]};
    @(posedge clk_i);
    gen_req <= 1'b1;
    gen_idx <= k[2:0];
    @(posedge clk_i);
    gen_req <= 1'b0;
    @(posedge clk_i);
    cmp_bit(gen_byte_vld_o, 1'b1);
    cmp_bit(gen_is_pat_o, k < v);
    cmp_reg({8'h00, gen_byte_o}, (k < v) ? {8'h00, p[8*k +: 8]} : 16'h0000);
  endtask
  task automatic rx_chk(input logic [47:0] da, input logic bad, input int gap, input logic e);
    last_match = 1'bx;
    pgc_far_end_i.send_rx(da, bad, gap);
    repeat (2) @(posedge clk_i);
    rxf = bad;
    cmp_bit(last_match, e);
    rd(`PGC_IDX_FLAGS, {14'h0000, rxf, txf});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    #200000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(12'(`PGC_IDX_PAY_LO + i), 16'h0000);
    rd(`PGC_IDX_FLAGS, 16'h0000);
    rd(`PGC_IDX_CNT_LO, 16'h0000);
    rd(`PGC_IDX_CTRL, {12'h000, `PGC_RST_EN, `PGC_RST_VLD});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      mw[i] = r[15:0];
      wb(1'b1, 12'(`PGC_IDX_PAY_LO + i), mw[i]);
    end
    for (int i = 0; i < 6; i++) rd(12'(`PGC_IDX_PAY_LO + i), mw[i]);
    wb(1'b1, 12'h700, 16'hFFFF);
    rd(12'h700, 16'h0000);
    wb(1'b1, `PGC_IDX_CTRL, 16'h000F);
    for (int k = 0; k < 8; k++) gen_chk(k, 6);
    wb(1'b1, `PGC_IDX_CTRL, 16'h000B);
    for (int k = 0; k < 8; k++) gen_chk(k, 3);
    $display("test words and generator done");
    rx_chk({mw[5], mw[4], mw[3]}, 1'b0, 0, 1'b1);
    rx_chk({mw[5], mw[4], mw[3]} ^ 48'h000000000001, 1'b1, 2, 1'b0);
    $display("test receive done");
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      b = r[0] | (i == 4);
      pgc_far_end_i.send_tx(b);
      cnt++;
      err += b;
      txf = b;
    end
    repeat (2) @(posedge clk_i);
    rd(`PGC_IDX_FLAGS, {14'h0000, rxf, txf});
    rd(`PGC_IDX_CNT_LO, cnt[15:0]);
    rd(`PGC_IDX_FLAGS, {14'h0000, rxf, txf});
    rd(`PGC_IDX_CNT_HI, cnt[31:16]);
    rd(`PGC_IDX_ERR_CNT, err[15:0]);
    rd(`PGC_IDX_CNT_LO, cnt[15:0]);
    rd(`PGC_IDX_CNT_HI, cnt[31:16]);
    rd(`PGC_IDX_ERR_CNT, err[15:0]);
    cnt = 0;
    err = 0;
    rd(`PGC_IDX_CNT_LO, cnt[15:0]);
    rd(`PGC_IDX_CNT_HI, cnt[31:16]);
    rd(`PGC_IDX_ERR_CNT, err[15:0]);
    $display("test statistics done");
    wb(1'b1, `PGC_IDX_CTRL, 16'h0007);
    pgc_far_end_i.send_tx(1'b0);
    txf = 1'b0;
    repeat (2) @(posedge clk_i);
    rd(`PGC_IDX_FLAGS, {14'h0000, rxf, txf});
    rd(`PGC_IDX_CNT_LO, 16'h0000);
    wb(1'b1, `PGC_IDX_CTRL, 16'h000F);
    pgc_far_end_i.send_tx(1'b0);
    repeat (2) @(posedge clk_i);
    rd(`PGC_IDX_CNT_LO, 16'h0001);
    $display("test enable done");
    test_done();
  end
endmodule
